//--- dv/rvdc_bench.sv
// Self-checking bench for the regulator and bus-power control block
`timescale 1ns/1ps
`include "rvdc_map.svh"
module rvdc_bench;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, attach = 0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, lag = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, rd, seed = 32'h51f289ba;
    logic [1:0] bresp, rresp, resp;
    logic awready, wready, bvalid, arready, rvalid, sense, reg_on, lp, birq, brst, irq;
    int n_mismatch = 0, check_count = 0, cyc = 0, ctrl_m = 0, st_m = 0, vb = 0;
    initial forever #5 aclk = ~aclk;
    rvdc_vbus_src src (.attach(attach), .lag_ns(lag), .vbus(sense));
    rvdc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus_power_sense(sense),
        .regulator_on_control(reg_on), .regulator_low_power_select(lp), .bus_power_irq(birq),
        .bus_power_reset_req(brst), .irq(irq));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Readies are combinational, so they are looked at mid-cycle, when every edge update has landed
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw, pb, ha, hw, hb;
        pa = 1;
        pw = 1;
        pb = 1;
        awaddr <= a;
        wdata <= d;
        awv <= 1;
        wv <= 1;
        bready <= 1;
        while (pa | pw | pb)
        begin
            @(negedge aclk);
            ha = pa & awready;
            hw = pw & wready;
            hb = pb & bvalid;
            if (hb)
                r = bresp;
            @(posedge aclk);
            if (ha)
                awv <= 0;
            if (hw)
                wv <= 0;
            if (hb)
                bready <= 0;
            pa = pa & !ha;
            pw = pw & !hw;
            pb = pb & !hb;
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic pa, pr, ha, hr;
        pa = 1;
        pr = 1;
        araddr <= a;
        arv <= 1;
        rready <= 1;
        while (pa | pr)
        begin
            @(negedge aclk);
            ha = pa & arready;
            hr = pr & rvalid;
            if (hr)
            begin
                d = rdata;
                r = rresp;
            end
            @(posedge aclk);
            if (ha)
                arv <= 0;
            if (hr)
                rready <= 0;
            pa = pa & !ha;
            pr = pr & !hr;
        end
    endtask : axi_rd
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        axi_wr(a, d, resp);
        chk(resp, `RVDC_RESP_OKAY);
        repeat (2) @(posedge aclk);
    endtask : wr
    task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        axi_rd(a, rd, resp);
        chk(rd, e);
        chk(resp, er);
    endtask : rdc
    // Plug or unplug with a random delay; the reference model records the edge it causes
    task automatic set_vbus(input int v);
        seed = lfsr(seed);
        lag <= seed[3:0];
        attach <= v[0];
        repeat (6) @(posedge aclk);
        if (v == 1 && vb == 0)
            st_m = st_m | 1;
        if (v == 0 && vb == 1)
            st_m = st_m | 2;
        vb = v;
    endtask : set_vbus
    // Hang guard well above the expected run length
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        chk(reg_on, 1);
        chk(lp, 0);
        rdc(`RVDC_OFF_CTRL, `RVDC_CTRL_RST, `RVDC_RESP_OKAY);
        $display("test reset values done");
        // Random control words, reserved bits included, must read back masked
        repeat (6)
        begin
            seed = lfsr(seed);
            wr(`RVDC_OFF_CTRL, seed);
            ctrl_m = seed[7:0] & `RVDC_CTRL_WMASK;
            rdc(`RVDC_OFF_CTRL, ctrl_m, `RVDC_RESP_OKAY);
            chk(reg_on, !ctrl_m[7]);
            chk(lp, ctrl_m[4]);
        end
        $display("test control bits done");
        for (int v = 0; v < 2; v++)
        begin
            set_vbus(v);
            rdc(`RVDC_OFF_CTRL, ctrl_m | (vb << 6), `RVDC_RESP_OKAY);
            for (int p = 0; p < 2; p++)
                for (int e = 0; e < 4; e++)
                begin
                    wr(`RVDC_OFF_CTRL, p << 5);
                    ctrl_m = p << 5;
                    wr(`RVDC_OFF_EN, e);
                    chk(birq, (vb == p) && e[0]);
                    chk(brst, (vb == p) && e[1]);
                end
        end
        // Polarity is high here, so unplugging must drop both requests with nothing latched
        set_vbus(0);
        chk(birq, 0);
        chk(brst, 0);
        rdc(`RVDC_OFF_CTRL, 32'h20, `RVDC_RESP_OKAY);
        $display("test level request done");
        wr(`RVDC_OFF_MASK, 3);
        rdc(`RVDC_OFF_STAT, st_m, `RVDC_RESP_OKAY);
        chk(irq, st_m != 0);
        wr(`RVDC_OFF_STAT, 3);
        st_m = 0;
        chk(irq, 0);
        wr(`RVDC_OFF_MASK, 1);
        set_vbus(1);
        set_vbus(0);
        rdc(`RVDC_OFF_STAT, st_m, `RVDC_RESP_OKAY);
        chk(irq, 1);
        wr(`RVDC_OFF_STAT, 1);
        chk(irq, 0);
        $display("test status interrupt done");
        rdc(4'h2, 0, `RVDC_RESP_SLVERR);
        axi_wr(4'h6, 32'hff, resp);
        chk(resp, `RVDC_RESP_SLVERR);
        // Let an edge pass so bready is not lowered and raised in one time step
        @(posedge aclk);
        // Second reset with the regulator switched off must turn it back on
        wr(`RVDC_OFF_CTRL, 32'h90);
        chk(reg_on, 0);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        repeat (4) @(posedge aclk);
        chk(reg_on, 1);
        chk(lp, 0);
        rdc(`RVDC_OFF_CTRL, 0, `RVDC_RESP_OKAY);
        $display("test second reset done");
        summarize();
    end
endmodule : rvdc_bench

//--- dv/rvdc_vbus_src.sv
// Bus-power source model: a cable plug whose supply follows after a settable delay
`timescale 1ns/1ps
module rvdc_vbus_src (
    input wire logic attach,
    input wire logic [3:0] lag_ns,
    output logic vbus
);
    // A real cable settles late and never floats: the line is always at a firm level
    initial vbus = 1'b0;
    always @(attach)
        vbus <= #(lag_ns) attach;
endmodule : rvdc_vbus_src

//--- rtl/rvdc_axil.sv
// AXI4-Lite slave front end: one write and one read channel pair
`timescale 1ns/1ps
`include "rvdc_map.svh"
module rvdc_axil (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`RVDC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`RVDC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [`RVDC_ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [`RVDC_ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    typedef struct packed {
        logic aw_held;
        logic w_held;
        logic [`RVDC_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } rvdc_axil_t;
    rvdc_axil_t state;
    rvdc_axil_t next_state;

    // Address and data are taken in either order; the write fires once both are held
    assign s_axi_awready = !state.aw_held && !state.bvalid;
    assign s_axi_wready = !state.w_held && !state.bvalid;
    assign s_axi_arready = !state.rvalid;
    assign wr_en = state.aw_held && state.w_held;
    assign wr_addr = state.awaddr;
    assign wr_data = state.wdata;
    assign wr_strb = state.wstrb;
    assign rd_addr = s_axi_araddr;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rresp = state.rresp;
    assign s_axi_rdata = state.rdata;

    always_comb
    begin
        next_state = state;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_state.aw_held = 1'b1;
            next_state.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_state.w_held = 1'b1;
            next_state.wdata = s_axi_wdata;
            next_state.wstrb = s_axi_wstrb;
        end
        if (wr_en)
        begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = wr_ok ? `RVDC_RESP_OKAY : `RVDC_RESP_SLVERR;
        end
        if (state.bvalid && s_axi_bready)
            next_state.bvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_state.rvalid = 1'b1;
            next_state.rdata = rd_data;
            next_state.rresp = rd_ok ? `RVDC_RESP_OKAY : `RVDC_RESP_SLVERR;
        end
        else if (state.rvalid && s_axi_rready)
            next_state.rvalid = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= '0;
        else
            state <= next_state;
    end
endmodule : rvdc_axil

//--- rtl/rvdc_map.svh
// Register map, field positions and reset values of the regulator and bus-power control block
// Operation
// RL1: Any reset brings the supply regulator up switched on.
// RL2: Software switches the regulator on or off through one control bit.
// RL3: A control bit selects low-power suspend regulator mode, else normal mode.
// RL4: A read-only bit always shows the present bus-power level, never latched.
// RL5: With interrupt enabled, request interrupt while bus power equals selected polarity.
// RL6: Bus-power interrupt is a pure level, no pending flag, active while matching.
// RL7: With reset source enabled, request system reset while bus power matches polarity.
// RL8: Regulator off control is bit 7; 1 disables; register resets to zero.
// RL9: Bus-power level flag is bit 6, read-only, 1 means power present.
// RL10: Polarity select bit 5: 0 active while low, 1 active while high.
// RL11: Low-power select is bit 4; bits 3 to 0 read zero.
// RL12: Bus-power sense is synchronised to the clock before any use.
`ifndef RVDC_MAP_SVH
`define RVDC_MAP_SVH
`define RVDC_ADDR_W 4
`define RVDC_OFF_CTRL 4'h0
`define RVDC_OFF_STAT 4'h4
`define RVDC_OFF_MASK 4'h8
`define RVDC_OFF_EN 4'hc
`define RVDC_BIT_OFF 7
`define RVDC_BIT_LEVEL 6
`define RVDC_BIT_POL 5
`define RVDC_BIT_LP 4
`define RVDC_CTRL_RST 8'h00
`define RVDC_CTRL_WMASK 8'hb0
`define RVDC_EV_RISE 0
`define RVDC_EV_FALL 1
`define RVDC_EN_IRQ 0
`define RVDC_EN_RST 1
`define RVDC_RESP_OKAY 2'b00
`define RVDC_RESP_SLVERR 2'b10
`endif

//--- rtl/rvdc_pkg.sv
// Types shared by the regulator and bus-power control block
package rvdc_pkg;
    typedef struct packed {
        logic stage1;
        logic stage2;
    } rvdc_sync_t;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [1:0] status;
        logic [1:0] mask;
        logic [1:0] enable;
        logic level_d;
    } rvdc_regs_t;
    typedef enum logic [1:0] {
        RVDC_IDLE = 2'b00,
        RVDC_RESP = 2'b01
    } rvdc_ch_t;
endpackage : rvdc_pkg

//--- rtl/rvdc_sync.sv
// Two-flop synchroniser for the bus-power sense input
`timescale 1ns/1ps
module rvdc_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic async_in,
    output logic sync_out
);
    rvdc_pkg::rvdc_sync_t state;
    rvdc_pkg::rvdc_sync_t next_state;

    // First stage feeds only the second one
    always_comb
    begin
        next_state.stage1 = async_in;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= '0;
        else
            state <= next_state;
    end

    assign sync_out = state.stage2; // RL12
endmodule : rvdc_sync

//--- rtl/rvdc_top.sv
// Regulator control and bus-power detection with AXI4-Lite registers
`timescale 1ns/1ps
`include "rvdc_map.svh"
module rvdc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`RVDC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`RVDC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic bus_power_sense,
    output logic regulator_on_control,
    output logic regulator_low_power_select,
    output logic bus_power_irq,
    output logic bus_power_reset_req,
    output logic irq
);
    rvdc_pkg::rvdc_regs_t state;
    rvdc_pkg::rvdc_regs_t next_state;
    logic level;
    logic match;
    logic wr_en;
    logic [`RVDC_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [`RVDC_ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [1:0] events;

    // Known register offsets; anything else answers SLVERR
    function automatic logic rvdc_mapped(input logic [`RVDC_ADDR_W-1:0] a);
        rvdc_mapped = (a == `RVDC_OFF_CTRL) || (a == `RVDC_OFF_STAT) ||
                      (a == `RVDC_OFF_MASK) || (a == `RVDC_OFF_EN);
    endfunction : rvdc_mapped

    rvdc_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(bus_power_sense),
        .sync_out(level)
    );

    rvdc_axil u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // Polarity match drives both the interrupt level and the reset request
    assign match = (level == state.ctrl[`RVDC_BIT_POL]); // RL5 RL10
    assign bus_power_irq = match && state.enable[`RVDC_EN_IRQ]; // RL5 RL6
    assign bus_power_reset_req = match && state.enable[`RVDC_EN_RST]; // RL7
    assign regulator_on_control = !state.ctrl[`RVDC_BIT_OFF]; // RL2 RL8
    assign regulator_low_power_select = state.ctrl[`RVDC_BIT_LP]; // RL3 RL11
    // Edge events are sticky extras; the level interrupt itself needs no clear
    assign events = {state.level_d && !level, !state.level_d && level};
    assign irq = |(state.status & state.mask);
    assign wr_ok = rvdc_mapped(wr_addr);
    assign rd_ok = rvdc_mapped(rd_addr);

    // Read mux: level bit is live, reserved bits zero
    always_comb
    begin
        rd_data = 32'h0;
        unique case (rd_addr)
            `RVDC_OFF_CTRL:
            begin
                rd_data[7:0] = state.ctrl & `RVDC_CTRL_WMASK; // RL11
                rd_data[`RVDC_BIT_LEVEL] = level; // RL4 RL9
            end
            `RVDC_OFF_STAT: rd_data[1:0] = state.status;
            `RVDC_OFF_MASK: rd_data[1:0] = state.mask;
            `RVDC_OFF_EN: rd_data[1:0] = state.enable;
            default: rd_data = 32'h0;
        endcase
    end

    // Register writes; a new event beats a write-one clear in the same cycle
    always_comb
    begin
        next_state = state;
        next_state.level_d = level;
        if (wr_en && wr_strb[0])
        begin
            unique case (wr_addr)
                `RVDC_OFF_CTRL: next_state.ctrl = wr_data[7:0] & `RVDC_CTRL_WMASK; // RL2 RL3
                `RVDC_OFF_STAT: next_state.status = state.status & ~wr_data[1:0];
                `RVDC_OFF_MASK: next_state.mask = wr_data[1:0];
                `RVDC_OFF_EN: next_state.enable = wr_data[1:0];
                default: next_state.status = next_state.status;
            endcase
        end
        next_state.status = next_state.status | events;
    end

    // Reset brings the regulator on since the off bit clears
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= '0; // RL1 RL8
            state.ctrl <= `RVDC_CTRL_RST;
        end
        else
            state <= next_state;
    end

    chk_reg_on_reset: assert property (@(posedge aclk) !aresetn |=> regulator_on_control) // RL1
        else $error("regulator not on after reset");
    // Checked against the raw pin two cycles back, so a broken synchroniser or match shows up
    chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
        bus_power_irq == (state.enable[`RVDC_EN_IRQ] && ($past(bus_power_sense, 2) == state.ctrl[`RVDC_BIT_POL])))
        else $error("interrupt level does not track match");
    chk_rst_match: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
        bus_power_reset_req == (state.enable[`RVDC_EN_RST] && ($past(bus_power_sense, 2) == state.ctrl[`RVDC_BIT_POL])))
        else $error("reset request does not track match");
    chk_off_write: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
        wr_en && wr_strb[0] && wr_addr == `RVDC_OFF_CTRL |=> regulator_on_control == !$past(wr_data[7]))
        else $error("off control write lost");
    chk_lp_write: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
        wr_en && wr_strb[0] && wr_addr == `RVDC_OFF_CTRL |=> regulator_low_power_select == $past(wr_data[4]))
        else $error("low power write lost");
    chk_sync_lat: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
        ##2 level == $past(bus_power_sense, 2))
        else $error("sense not two-flop synchronised");
    chk_level_read: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
        rd_addr == `RVDC_OFF_CTRL |-> rd_data[`RVDC_BIT_LEVEL] == level && rd_data[3:0] == 4'h0)
        else $error("level read wrong");
    chk_pol_high: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
        state.ctrl[`RVDC_BIT_POL] && state.enable[`RVDC_EN_IRQ] && level |-> bus_power_irq)
        else $error("high polarity missed");
endmodule : rvdc_top
